// ### hw/sbd_defs.vh
// Purpose: constants for the single wire debug port
// Assumes: 100 MHz ref_clk, one debug bit clock per ref_clk cycle
// Notes:   definitions only
`ifndef SBD_DEFS_VH
`define SBD_DEFS_VH
`define SBD_BIT_CYC        5'd16
`define SBD_SAMPLE_CYC     5'd10
`define SBD_PULSE1_CYC     5'd7
`define SBD_ZERO_LOW_CYC   5'd13
`define SBD_TIMEOUT_CYC    11'd512
`define SBD_STEAL_CYC      8'd128
`define SBD_RESUME_CYC     8'd16
`define SBD_OP_BACKGROUND  8'h90
`define SBD_OP_RD_BD_BYTE  8'he4
`define SBD_OP_RD_BD_WORD  8'hec
`define SBD_OP_RD_BYTE     8'he0
`define SBD_OP_RD_WORD     8'he8
`define SBD_OP_WR_BD_BYTE  8'hc4
`define SBD_OP_WR_BD_WORD  8'hcc
`define SBD_OP_WR_BYTE     8'hc0
`define SBD_OP_WR_WORD     8'hc8
`define SBD_MAP_BASE       16'hff00
`define SBD_REG_TOP        16'hff06
`define SBD_STATUS_ADDR    16'hff01
`define SBD_ENABLE_BIT     7
`endif

// ### hw/sbd_port.v
// Purpose: target end of the single wire background debug port
// Assumes: debug_wire_in synchronous enough to pass two flops; cpu handshake
// Notes:   hardware commands only; firmware runs on the cpu
// Operation
// [R1] firmware usable after enable bit write
// [R2] active mode maps debug space, halts cpu
// [R3] enter via command, tag, or halt instruction
// [R4] enter at instruction boundary, tag before execute
// [R5] special single chip starts active
// [R6] debug registers hidden from user programs
// [R7] suspend-enabled peripherals halt while active
// [R8] host starts every bit with falling edge
// [R9] msb first, sixteen cycles per bit
// [R10] 512 idle cycles clears command
// [R11] detect start, sample ten cycles later
// [R12] target never drives during host bits
// [R13] host releases early when reading
// [R14] one bit gets speed-up pulse at seven
// [R15] host samples about ten cycles in
// [R16] zero bit held low thirteen cycles
// [R17] use free cycle, steal after 128
// [R18] enter-debug only when firmware enabled
// [R19] in-map byte read, out-of-map reads
// [R20] out-of-map writes with address and data
// [R21] in-map byte write to debug space
// [R22] odd address low byte, even high
// [R23] host uses aligned word addresses
// [R24] debug space enabled only for access
// [R25] opcode then address and data fields
// [R26] host waits 150 cycles between phases
// [R27] two-flop synchroniser before edge detect
`timescale 1ns/1ps
`default_nettype none
`include "sbd_defs.vh"
module sbd_port
(
    input  wire        ref_clk,
    input  wire        srst,
    input  wire        special_single_chip,
    input  wire        debug_wire_in,
    output reg         debug_wire_out,
    output reg         debug_wire_oe,
    input  wire        cpu_boundary,
    input  wire        cpu_tag_hit,
    input  wire        cpu_halt_instr,
    input  wire        cpu_user_access,
    input  wire        bus_free,
    output reg         bus_req,
    output reg         bus_we,
    output reg         bus_inmap,
    output reg  [15:0] bus_addr,
    output reg  [15:0] bus_wdata,
    input  wire [15:0] bus_rdata,
    output reg         cpu_freeze,
    output reg         debug_active,
    output reg         fw_enabled,
    output reg         periph_suspend,
    output reg         user_map_block
);
    // command phases
    localparam ST_OP = 3'd0;
    localparam ST_ADDR = 3'd1;
    localparam ST_WDATA = 3'd2;
    localparam ST_ACC = 3'd3;
    localparam ST_RDATA = 3'd4;
    localparam ST_EXIT = 3'd5;

    // read command test used by the decoder and the access path
    function is_read;
        input [7:0] op;
        begin
            is_read = (op[7:4] == 4'he);
        end
    endfunction
    function is_inmap;
        input [7:0] op;
        begin
            is_inmap = op[2];
        end
    endfunction
    ////////////////////////////////////////////////////////////////////////
    // wire synchroniser and edge detect
    reg        sync1_ff;
    reg        sync2_ff;
    reg        sync3_ff;
    always @(posedge ref_clk)
    begin
        if (srst)
        begin
            sync1_ff <= 1'b1;
            sync2_ff <= 1'b1;
            sync3_ff <= 1'b1;
        end
        else
        begin
            sync1_ff <= debug_wire_in; // [R27]
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
        end
    end
    // start only counted when we are not driving the wire ourselves
    wire fall = sync3_ff & ~sync2_ff & ~debug_wire_oe; // [R11] [R8]
    ////////////////////////////////////////////////////////////////////////
    // bit timing and shifter
    reg  [2:0]  st_ff;
    reg  [7:0]  op_ff;
    reg  [15:0] sh_ff;
    reg  [4:0]  cnt_ff;
    reg  [4:0]  nbits_ff;
    reg         inbit_ff;
    reg         txbit_ff;
    reg  [9:0]  idle_ff;
    reg  [7:0]  wait_ff;
    reg  [7:0]  resume_ff;
    reg         enter_req_ff;
    reg         strap_done_ff;
    wire        tx_phase = (st_ff == ST_RDATA);
    wire [10:0] idle_lim = `SBD_TIMEOUT_CYC - 11'd1;
    wire        timeout = (idle_ff == idle_lim[9:0]) & ~fall;
    wire        sample = inbit_ff & (cnt_ff == `SBD_SAMPLE_CYC) & ~tx_phase;
    wire        last_bit = (nbits_ff == 5'd1);
    // idle counter times out a stalled host
    always @(posedge ref_clk)
    begin
        if (srst || fall || st_ff == ST_OP && nbits_ff == 5'd8 && !inbit_ff)
            idle_ff <= 10'd0;
        else if (idle_ff != idle_lim[9:0])
            idle_ff <= idle_ff + 10'd1; // [R10]
        else
            idle_ff <= 10'd0;
    end
    // wire driver: zero low for 13, one pulses at 7
    always @(posedge ref_clk)
    begin
        if (srst || !tx_phase)
        begin
            debug_wire_out <= 1'b1;
            debug_wire_oe  <= 1'b0; // [R12]
        end
        else if (inbit_ff && !txbit_ff && cnt_ff < `SBD_ZERO_LOW_CYC)
        begin
            debug_wire_out <= 1'b0; // [R16]
            debug_wire_oe  <= 1'b1;
        end
        else if (inbit_ff && (cnt_ff == `SBD_ZERO_LOW_CYC && !txbit_ff
                 || cnt_ff == `SBD_PULSE1_CYC && txbit_ff))
        begin
            debug_wire_out <= 1'b1; // [R14]
            debug_wire_oe  <= 1'b1;
        end
        else
        begin
            debug_wire_out <= 1'b1;
            debug_wire_oe  <= 1'b0;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // command sequencer
    always @(posedge ref_clk)
    begin
        if (srst)
        begin
            st_ff <= ST_OP;
            op_ff <= 8'h00;
            sh_ff <= 16'h0000;
            cnt_ff <= 5'd0;
            nbits_ff <= 5'd8;
            inbit_ff <= 1'b0;
            txbit_ff <= 1'b1;
            wait_ff <= 8'd0;
            bus_req <= 1'b0;
            bus_we <= 1'b0;
            bus_inmap <= 1'b0;
            bus_addr <= 16'h0000;
            bus_wdata <= 16'h0000;
            cpu_freeze <= 1'b0;
            fw_enabled <= 1'b0;
            enter_req_ff <= 1'b0;
        end
        else if (timeout)
        begin
            st_ff <= ST_OP; // [R10]
            op_ff <= 8'h00;
            nbits_ff <= 5'd8;
            inbit_ff <= 1'b0;
            bus_req <= 1'b0;
            bus_inmap <= 1'b0;
            cpu_freeze <= 1'b0;
        end
        else
        begin
            if (enter_req_ff && (cpu_boundary || debug_active))
                enter_req_ff <= 1'b0;
            // bit timing: sixteen cycles from each detected start
            if (fall && st_ff != ST_ACC)
            begin
                inbit_ff <= 1'b1;
                cnt_ff <= 5'd1;
                txbit_ff <= sh_ff[15]; // [R9]
            end
            else if (inbit_ff)
            begin
                if (cnt_ff == `SBD_BIT_CYC - 5'd1)
                    inbit_ff <= 1'b0;
                cnt_ff <= cnt_ff + 5'd1;
            end
            if (sample)
            begin
                sh_ff <= {sh_ff[14:0], sync2_ff}; // [R9]
                nbits_ff <= nbits_ff - 5'd1;
            end
            else if (tx_phase && inbit_ff && cnt_ff == `SBD_BIT_CYC - 5'd1)
            begin
                sh_ff <= {sh_ff[14:0], 1'b0};
                nbits_ff <= nbits_ff - 5'd1;
                if (last_bit)
                begin
                    st_ff <= ST_OP;
                    nbits_ff <= 5'd8;
                end
            end
            case (st_ff)
            ST_OP:
                if (sample && last_bit)
                begin
                    op_ff <= {sh_ff[6:0], sync2_ff}; // [R25]
                    nbits_ff <= 5'd16;
                    if ({sh_ff[6:0], sync2_ff} == `SBD_OP_BACKGROUND)
                    begin
                        nbits_ff <= 5'd8;
                        if (fw_enabled)
                            enter_req_ff <= 1'b1; // [R18]
                    end
                    else
                        st_ff <= ST_ADDR;
                end
            ST_ADDR:
                if (sample && last_bit)
                begin
                    bus_addr <= {sh_ff[14:0], sync2_ff};
                    inbit_ff <= 1'b0; // a short access must not shift the dead tail
                    nbits_ff <= 5'd16;
                    wait_ff <= 8'd0;
                    st_ff <= is_read(op_ff) ? ST_ACC : ST_WDATA; // [R19] [R20]
                end
            ST_WDATA:
                if (sample && last_bit)
                begin
                    bus_wdata <= {sh_ff[14:0], sync2_ff};
                    wait_ff <= 8'd0;
                    st_ff <= ST_ACC;
                end
            ST_ACC:
                begin
                    // wait up to 128 cycles for a free cycle, then freeze and steal one
                    if (!bus_req)
                    begin
                        if (bus_free || cpu_freeze)
                        begin
                            bus_req <= 1'b1; // [R17]
                            bus_we <= ~is_read(op_ff);
                            bus_inmap <= is_inmap(op_ff); // [R24]
                        end
                        else if (wait_ff == `SBD_STEAL_CYC - 8'd1)
                            cpu_freeze <= 1'b1; // [R17]
                        else
                            wait_ff <= wait_ff + 8'd1;
                    end
                    else
                    begin
                        bus_req <= 1'b0;
                        bus_we <= 1'b0;
                        bus_inmap <= 1'b0; // [R24]
                        cpu_freeze <= 1'b0;
                        nbits_ff <= 5'd16;
                        if (is_read(op_ff))
                        begin
                            sh_ff <= bus_rdata; // [R22] memory returns lane-placed data
                            st_ff <= ST_RDATA;
                        end
                        else
                        begin
                            nbits_ff <= 5'd8;
                            st_ff <= ST_OP;
                            if (is_inmap(op_ff) && bus_addr == `SBD_STATUS_ADDR)
                                fw_enabled <= bus_addr[0] ? // [R1] [R21] [R22]
                                    bus_wdata[`SBD_ENABLE_BIT] :
                                    bus_wdata[`SBD_ENABLE_BIT + 8];
                        end
                    end
                end
            default:
                ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // active background mode and the brief resume when not enabled
    always @(posedge ref_clk)
    begin
        if (srst)
        begin
            debug_active <= 1'b0;
            resume_ff <= 8'd0;
        end
        else if (!strap_done_ff && special_single_chip)
            debug_active <= 1'b1; // [R5]
        else if (enter_req_ff && cpu_boundary || cpu_tag_hit && fw_enabled
                 || cpu_halt_instr && fw_enabled)
            debug_active <= 1'b1; // [R3] [R4]
        else if ((cpu_tag_hit || cpu_halt_instr) && !fw_enabled)
            resume_ff <= `SBD_RESUME_CYC; // [R3]
        else if (resume_ff != 8'd0)
            resume_ff <= resume_ff - 8'd1;
    end

    // strap caught on the first cycle after reset release; the mode
    // outputs cover that cycle before debug_active has risen
    always @(posedge ref_clk)
    begin
        if (srst)
        begin
            strap_done_ff <= 1'b0;
            periph_suspend <= 1'b0;
            user_map_block <= 1'b0;
        end
        else
        begin
            strap_done_ff <= 1'b1;
            periph_suspend <= debug_active | (!strap_done_ff & special_single_chip); // [R7]
            user_map_block <= (debug_active | (!strap_done_ff & special_single_chip))
                              & cpu_user_access; // [R2] [R6]
        end
    end
endmodule // sbd_port
`default_nettype wire

// ### tb/sbd_host_model.sv
// Purpose: host debug pod on the single debug wire
// Assumes: wire pulled up whenever nobody pulls it low
// Notes:   releases the wire rather than driving it high
`timescale 1ns/1ps
`default_nettype none
module sbd_host_model
(
    input  wire logic ref_clk,
    input  wire logic wire_lvl,
    output var  logic host_low
);
    initial host_low = 1'b0;
    ////////////////////////////////////////////////////////////////
    // one bit time of 16 cycles, always opened by a fall
    task automatic put_bit(input logic b);
        for (int i = 0; i < 16; i++)
        begin
            @(posedge ref_clk);
            #1 host_low = (i < 2) || (!b && i < 13);
        end
    endtask
    // held low 4 cycles so a target zero takes over without a glitch;
    // 20 cycles let the target's zero end before the next fall
    task automatic get_bit(output logic b);
        for (int i = 0; i < 20; i++)
        begin
            @(posedge ref_clk);
            #1 host_low = (i < 4);
            if (i == 10)
                b = wire_lvl;
        end
    endtask
    task automatic send(input logic [23:0] v, input int n);
        for (int k = n - 1; k >= 0; k--)
            put_bit(v[k]);
    endtask
    task automatic recv(output logic [15:0] v);
        for (int k = 15; k >= 0; k--)
            get_bit(v[k]);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
endmodule // sbd_host_model
`default_nettype wire

// ### tb/sbd_port_sva.sv
// Purpose: assertions on the debug wire and bus side of sbd_port
// Assumes: one ref_clk domain, srst synchronous active high
// Notes:   attached by the bind at the foot
`timescale 1ns/1ps
`default_nettype none
module sbd_port_sva
(
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic debug_wire_in,
    input wire logic debug_wire_out,
    input wire logic debug_wire_oe,
    input wire logic bus_free,
    input wire logic bus_req,
    input wire logic bus_inmap,
    input wire logic cpu_freeze,
    input wire logic debug_active,
    input wire logic periph_suspend
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    logic       drv_lo;
    logic       drv_hi;
    logic [7:0] busy_ff;
    // target drive state of the wire
    assign drv_lo = debug_wire_oe & ~debug_wire_out;
    assign drv_hi = debug_wire_oe & debug_wire_out;
    // run of cycles with no free bus slot, saturating
    always_ff @(posedge ref_clk)
        busy_ff <= (srst | bus_free) ? 8'h00 : busy_ff + {7'h00, ~&busy_ff};
    ////////////////////////////////////////////////////////////////
    sequence s_low_ends;
        drv_lo ##1 !drv_lo;
    endsequence
    a_req_one_cycle: assert property (bus_req |=> !bus_req)
        else $error("bus request held too long");
    a_inmap_in_access: assert property (bus_inmap |-> bus_req)
        else $error("debug map enabled outside an access");
    a_zero_low_hold: assert property ($rose(drv_lo) |-> drv_lo [*8])
        else $error("zero bit low drive too short");
    a_zero_then_high: assert property (s_low_ends |-> drv_hi)
        else $error("zero bit not ended by a high pulse");
    a_pulse_brief: assert property (not (drv_hi [*4]))
        else $error("speed-up pulse too long");
    a_steal_wait: assert property ($rose(cpu_freeze) |-> busy_ff >= 8'd120)
        else $error("cpu frozen before the free slot wait");
    a_quiet_at_fall: assert property ($fell(debug_wire_in) && !debug_wire_oe |=> !debug_wire_oe)
        else $error("target drives during host low time");
    a_suspend_follow: assert property (debug_active [*3] |-> periph_suspend)
        else $error("peripherals not suspended while active");
endmodule // sbd_port_sva
bind sbd_port sbd_port_sva i_sva
(
    .ref_clk(ref_clk), .srst(srst), .debug_wire_in(debug_wire_in),
    .debug_wire_out(debug_wire_out), .debug_wire_oe(debug_wire_oe),
    .bus_free(bus_free), .bus_req(bus_req), .bus_inmap(bus_inmap),
    .cpu_freeze(cpu_freeze), .debug_active(debug_active),
    .periph_suspend(periph_suspend)
);
`default_nettype wire

// ### tb/testbench.sv
// Purpose: self-checking bench for the single wire debug port
// Assumes: host pod model on the wire, word memory on the bus
// Notes:   each scenario judges its own results
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        ref_clk, srst, ssc, bus_free, bnd, host_low;
    logic        tag, halt, uacc, ublk;
    logic        out, oe, req, we, inmap, freeze, active, fw, susp;
    logic        cap_we, cap_in, frz_seen;
    logic [15:0] addr, wdata, rdata, cap_a, cap_d, r;
    wire         wire_lvl;
    int          fail_count, cmp_count;
    // pull-up wins unless someone pulls low; memory word mixes its address
    assign wire_lvl = ~host_low & (~oe | out);
    assign rdata = {addr[7:0], ~addr[15:8]};
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    sbd_host_model i_host (.ref_clk(ref_clk), .wire_lvl(wire_lvl), .host_low(host_low));
    sbd_port i_dut
    (
        .ref_clk(ref_clk), .srst(srst), .special_single_chip(ssc),
        .debug_wire_in(wire_lvl), .debug_wire_out(out), .debug_wire_oe(oe),
        .cpu_boundary(bnd), .cpu_tag_hit(tag), .cpu_halt_instr(halt),
        .cpu_user_access(uacc), .bus_free(bus_free), .bus_req(req), .bus_we(we),
        .bus_inmap(inmap), .bus_addr(addr), .bus_wdata(wdata), .bus_rdata(rdata),
        .cpu_freeze(freeze), .debug_active(active), .fw_enabled(fw),
        .periph_suspend(susp), .user_map_block(ublk)
    );
    // capture each bus access as the port makes it
    always @(posedge ref_clk)
    begin
        if (req)
            {cap_a, cap_d, cap_we, cap_in} <= {addr, wdata, we, inmap};
        if (freeze)
            frz_seen <= 1'b1;
    end
    ////////////////////////////////////////////////////////////////
    task automatic check(input string nm, input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic results;
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic rst(input logic s);
        #1 {srst, ssc} = {1'b1, s};
        repeat (4) @(posedge ref_clk);
        #1 srst = 1'b0;
        i_host.idle(3);
        check("active", {15'h0, active}, {15'h0, s});
        check("wire", {14'h0, oe, out}, 16'h1);
    endtask
    task automatic pulse;
        #1 bnd = 1'b1;
        @(posedge ref_clk);
        #1 bnd = 1'b0;
    endtask
    // opcode, address, then write data or read data after the wait
    task automatic cmd(input logic [7:0] op, input logic [15:0] a, input logic [15:0] d);
        i_host.send({16'h0, op}, 8);
        if (op != 8'h90)
            i_host.send({8'h0, a}, 16);
        if (op[5])
        begin
            i_host.idle(150);
            i_host.recv(r);
        end
        else if (op != 8'h90)
            i_host.send({8'h0, d}, 16);
        i_host.idle(150);
    endtask
    task automatic t_word;
        #1 frz_seen = 1'b0;
        cmd(8'hc8, 16'h1234, 16'hbeef);
        check("wr addr", cap_a, 16'h1234);
        check("wr data", cap_d, 16'hbeef);
        check("wr kind", {14'h0, cap_we, cap_in}, 16'h2);
        cmd(8'he8, 16'h2468, 16'h0);
        check("rd data", r, 16'h68db);
        check("rd kind", {14'h0, cap_we, cap_in}, 16'h0);
        check("no freeze", {15'h0, frz_seen}, 16'h0);
    endtask
    task automatic t_byte;
        cmd(8'he0, 16'h1001, 16'h0);
        check("odd byte", {8'h0, r[7:0]}, 16'h00ef);
        cmd(8'he4, 16'h10a6, 16'h0);
        check("even byte", {8'h0, r[15:8]}, 16'h00a6);
        check("inmap rd", {15'h0, cap_in}, 16'h1);
    endtask
    // enter-debug refused until firmware enabled, then taken at a boundary
    task automatic t_enter;
        cmd(8'h90, 16'h0, 16'h0);
        pulse();
        i_host.idle(40);
        check("no fw", {15'h0, active}, 16'h0);
        cmd(8'hc4, 16'hff01, 16'h0080);
        check("fw bit", {15'h0, fw}, 16'h1);
        check("st addr", cap_a, 16'hff01);
        check("inmap wr", {15'h0, cap_in}, 16'h1);
        cmd(8'h90, 16'h0, 16'h0);
        check("wait bnd", {15'h0, active}, 16'h0);
        pulse();
        i_host.idle(4);
        check("active", {15'h0, active}, 16'h1);
        check("suspend", {15'h0, susp}, 16'h1);
        #1 uacc = 1'b1;
        i_host.idle(2);
        check("user blk", {15'h0, ublk}, 16'h1);
        #1 uacc = 1'b0;
    endtask
    // tag and halt refused before firmware enable, each taken after it
    task automatic t_tag;
        rst(1'b0);
        #1 {tag, halt, uacc} = 3'b111;
        @(posedge ref_clk);
        #1 {tag, halt} = 2'b00;
        i_host.idle(4);
        check("no tag", {15'h0, active}, 16'h0);
        check("user open", {15'h0, ublk}, 16'h0);
        #1 uacc = 1'b0;
        cmd(8'hc4, 16'hff01, 16'h0080);
        #1 tag = 1'b1;
        @(posedge ref_clk);
        #1 tag = 1'b0;
        i_host.idle(2);
        check("tag entry", {15'h0, active}, 16'h1);
        rst(1'b0);
        cmd(8'hc4, 16'hff01, 16'h0080);
        #1 halt = 1'b1;
        @(posedge ref_clk);
        #1 halt = 1'b0;
        i_host.idle(2);
        check("halt entry", {15'h0, active}, 16'h1);
    endtask
    // no free bus slot: the cpu is frozen and the read still completes
    task automatic t_steal;
        #1 {frz_seen, bus_free} = 2'b00;
        cmd(8'he8, 16'h3c5a, 16'h0);
        #1 bus_free = 1'b1;
        check("froze", {15'h0, frz_seen}, 16'h1);
        check("st data", r, 16'h5ac3);
    endtask
    // a command cut off mid opcode is dropped after the idle limit
    task automatic t_timeout;
        i_host.send(24'h0c, 4);
        i_host.idle(600);
        cmd(8'he8, 16'h0246, 16'h0);
        check("after idle", r, 16'h46fd);
    endtask
    initial
    begin
        {srst, ssc, bus_free, bnd, tag, halt, uacc} = 7'b1010000;
        {fail_count, cmp_count} = 0;
        rst(1'b0);
        t_word();
        $display("word access test done");
        t_byte();
        $display("byte access test done");
        t_steal();
        $display("cycle steal test done");
        t_timeout();
        $display("idle limit test done");
        t_enter();
        $display("debug entry test done");
        t_tag();
        $display("tag entry test done");
        rst(1'b1);
        $display("special start test done");
        results();
    end
    initial
    begin
        #1_000_000;
        fail_count++;
        results();
    end
endmodule // testbench
`default_nettype wire
